/* core/cyclg_gate.sv */
// one registered basic gate of the basic_gate_list
`timescale 1ns/10ps
`default_nettype none
module cyclg_gate #(
  parameter cyclg_pkg::cyclg_kind_type KIND = cyclg_pkg::K_AND
) (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // program cycle strobe
  input  wire logic       cyc_stb,
  // inputs and per-input configuration
  input  wire logic [3:0] gin,
  input  wire logic [3:0] conn,
  input  wire logic [3:0] inv,
  // registered output
  output logic            gout
);
  logic [3:0] eff;
  logic [3:0] prev_q;
  logic       prev_vld_q;
  logic       gout_d;
  logic       gout_q;

  // and-type gates see 1 on open inputs, the rest see 0
  localparam logic OPEN_LVL = (KIND == cyclg_pkg::K_AND) || (KIND == cyclg_pkg::K_ANDE) ||
                              (KIND == cyclg_pkg::K_NAND) || (KIND == cyclg_pkg::K_NANDE);
  assign eff = (conn & (gin ^ inv)) | (~conn & {4{OPEN_LVL}});

  wire all_hi  = &eff;
  wire prev_hi = &prev_q;

  always_comb begin
    case (KIND)
      cyclg_pkg::K_AND:   gout_d = all_hi;
      cyclg_pkg::K_ANDE:  gout_d = prev_vld_q & all_hi & ~prev_hi;
      cyclg_pkg::K_NAND:  gout_d = ~all_hi;
      cyclg_pkg::K_NANDE: gout_d = prev_vld_q & ~all_hi & prev_hi;
      cyclg_pkg::K_OR:    gout_d = |eff;
      cyclg_pkg::K_NOR:   gout_d = ~|eff;
      cyclg_pkg::K_XOR:   gout_d = eff[0] ^ eff[1];
      default:            gout_d = ~eff[0];
    endcase
  end

  // history only counts once a real cycle has been seen, so cycle one never shows an edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q     <= 4'h0;
      prev_vld_q <= 1'b0;
      gout_q     <= 1'b0;
    end else if (cyc_stb) begin
      prev_q     <= eff;
      prev_vld_q <= 1'b1;
      gout_q     <= gout_d;
    end
  end

  assign gout = gout_q;

  property p_gate_hold;
    @(posedge hclk) disable iff (!hresetn) !cyc_stb |=> $stable(gout);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("gate output moved between cycles");

  property p_first_no_edge;
    @(posedge hclk) disable iff (!hresetn)
      cyc_stb && !prev_vld_q && (KIND == cyclg_pkg::K_ANDE || KIND == cyclg_pkg::K_NANDE) |=> !gout;
  endproperty
  a_first_no_edge: assert property (p_first_no_edge) else $error("edge reported in first cycle");

  property p_ande_rise;
    @(posedge hclk) disable iff (!hresetn)
      cyc_stb && KIND == cyclg_pkg::K_ANDE && prev_vld_q |=> gout == ($past(all_hi) && !$past(prev_hi));
  endproperty
  a_ande_rise: assert property (p_ande_rise) else $error("edge and output wrong");

  property p_nande_fall;
    @(posedge hclk) disable iff (!hresetn)
      cyc_stb && KIND == cyclg_pkg::K_NANDE && prev_vld_q |=> gout == (!$past(all_hi) && $past(prev_hi));
  endproperty
  a_nande_fall: assert property (p_nande_fall) else $error("edge nand output wrong");

  property p_open_and;
    @(posedge hclk) disable iff (!hresetn)
      cyc_stb && conn == 4'h0 && KIND == cyclg_pkg::K_AND |=> gout;
  endproperty
  a_open_and: assert property (p_open_and) else $error("open and inputs not high");

  property p_open_or;
    @(posedge hclk) disable iff (!hresetn)
      cyc_stb && conn == 4'h0 && KIND == cyclg_pkg::K_OR |=> !gout;
  endproperty
  a_open_or: assert property (p_open_or) else $error("open or inputs not low");
endmodule // cyclg_gate
`default_nettype wire

/* core/cyclg_pkg.sv */
// constants and types shared by the cycle logic gate block
package cyclg_pkg;
  // clock and program cycle
  localparam int unsigned CLK_HZ     = 50_000_000;
  localparam logic [15:0] DIV_RST    = 16'h03E7;
  // gate array shape
  localparam int unsigned NUM_GATES  = 8;
  localparam int unsigned GATE_W     = 4;
  // register byte offsets
  localparam logic [7:0]  CTRL_OFF   = 8'h00;
  localparam logic [7:0]  DIV_OFF    = 8'h04;
  localparam logic [7:0]  CONN_OFF   = 8'h08;
  localparam logic [7:0]  INV_OFF    = 8'h0C;
  localparam logic [7:0]  SFB_OFF    = 8'h10;
  localparam logic [7:0]  TPAR_OFF   = 8'h14;
  localparam logic [7:0]  STAT_OFF   = 8'h18;
  localparam logic [7:0]  TVAL_OFF   = 8'h1C;
  localparam logic [7:0]  CNT_OFF    = 8'h20;
  // register reset values
  localparam logic [31:0] CONN_RST   = 32'h0000_0000;
  localparam logic [31:0] INV_RST    = 32'h0000_0000;
  localparam logic [9:0]  SFB_RST    = 10'h000;
  localparam logic [17:0] TPAR_RST   = 18'h0_0000;
  // special block input positions
  localparam int unsigned SF_SET     = 0;
  localparam int unsigned SF_RST     = 1;
  localparam int unsigned SF_EN      = 2;
  localparam int unsigned SF_INV     = 3;
  localparam int unsigned SF_RALL    = 4;
  localparam int unsigned SF_W       = 5;
  localparam int unsigned SF_INV_LSB = 5;
  // time parameter fields
  localparam int unsigned TP_MINOR   = 0;
  localparam int unsigned TP_MAJOR   = 8;
  localparam int unsigned TP_BASE    = 16;
  localparam logic [6:0]  MULT_SEC   = 7'h64;
  localparam logic [6:0]  MULT_MINHR = 7'h3C;
  // status fields
  localparam int unsigned ST_SFB     = 8;
  localparam int unsigned ST_ELAPSED = 9;
  localparam int unsigned ST_FLAG    = 10;

  typedef enum logic [1:0] {
    TB_SEC  = 2'b00,
    TB_MIN  = 2'b01,
    TB_HOUR = 2'b10
  } cyclg_base_type;

  typedef enum logic [2:0] {
    K_AND   = 3'b000,
    K_ANDE  = 3'b001,
    K_NAND  = 3'b010,
    K_NANDE = 3'b011,
    K_OR    = 3'b100,
    K_NOR   = 3'b101,
    K_XOR   = 3'b110,
    K_NOT   = 3'b111
  } cyclg_kind_type;
endpackage

/* core/cyclg_top.sv */
// cycle logic gate block: gate array, special block controls, time decode, ahb-lite registers
`timescale 1ns/10ps
`default_nettype none
module cyclg_top (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // block inputs
  input  wire logic [31:0] gate_in,
  input  wire logic [4:0]  sfb_in,
  input  wire logic        flag_in,
  // block outputs
  output logic      [7:0]  gate_out,
  output logic             sfb_out,
  output logic             flag_out,
  output logic             cycle_stb
);

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave

  logic        run_q;
  logic [15:0] div_q;
  logic [31:0] conn_q;
  logic [31:0] inv_q;
  logic [9:0]  sfb_cfg_q;
  logic [17:0] tpar_q;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_val;

  // only whole-word transfers exist on this bus; hsize is not decoded
  wire        addr_ok  = hsel && htrans[1] && hready;
  wire        rd_take  = addr_ok && !hwrite;
  wire        wr_take  = addr_ok && hwrite;
  wire [7:0]  rd_off   = {haddr[7:2], 2'b00};
  wire        hit_hi   = (haddr[31:8] == 24'h00_0000);
  wire        wr_ctrl  = wr_pend_q && (wr_addr_q == cyclg_pkg::CTRL_OFF);
  wire        wr_div   = wr_pend_q && (wr_addr_q == cyclg_pkg::DIV_OFF);
  wire        wr_conn  = wr_pend_q && (wr_addr_q == cyclg_pkg::CONN_OFF);
  wire        wr_inv   = wr_pend_q && (wr_addr_q == cyclg_pkg::INV_OFF);
  wire        wr_sfb   = wr_pend_q && (wr_addr_q == cyclg_pkg::SFB_OFF);
  wire        wr_tpar  = wr_pend_q && (wr_addr_q == cyclg_pkg::TPAR_OFF);

  logic [31:0] status_w;
  logic [17:0] tval_w;
  logic [15:0] cnt_q;

  always_comb begin
    rd_val = 32'h0000_0000;
    if (!hit_hi) begin
      rd_val = 32'h0000_0000;
    end else if (rd_off == cyclg_pkg::CTRL_OFF) begin
      rd_val = {31'h0000_0000, run_q};
    end else if (rd_off == cyclg_pkg::DIV_OFF) begin
      rd_val = {16'h0000, div_q};
    end else if (rd_off == cyclg_pkg::CONN_OFF) begin
      rd_val = conn_q;
    end else if (rd_off == cyclg_pkg::INV_OFF) begin
      rd_val = inv_q;
    end else if (rd_off == cyclg_pkg::SFB_OFF) begin
      rd_val = {22'h00_0000, sfb_cfg_q};
    end else if (rd_off == cyclg_pkg::TPAR_OFF) begin
      rd_val = {14'h0000, tpar_q};
    end else if (rd_off == cyclg_pkg::STAT_OFF) begin
      rd_val = status_w;
    end else if (rd_off == cyclg_pkg::TVAL_OFF) begin
      rd_val = {14'h0000, tval_w};
    end else if (rd_off == cyclg_pkg::CNT_OFF) begin
      rd_val = {16'h0000, cnt_q};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q  <= 32'h0000_0000;
    end else begin
      if (hready) begin
        wr_pend_q <= wr_take && hit_hi;
        wr_addr_q <= {haddr[7:2], 2'b00};
      end
      if (rd_take) begin
        hrdata_q <= rd_val;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q     <= 1'b0;
      div_q     <= cyclg_pkg::DIV_RST;
      conn_q    <= cyclg_pkg::CONN_RST;
      inv_q     <= cyclg_pkg::INV_RST;
      sfb_cfg_q <= cyclg_pkg::SFB_RST;
      tpar_q    <= cyclg_pkg::TPAR_RST;
    end else begin
      if (wr_ctrl) run_q <= hwdata[0];
      if (wr_div)  div_q <= hwdata[15:0];
      if (wr_conn) conn_q <= hwdata;
      if (wr_inv)  inv_q <= hwdata;
      if (wr_sfb)  sfb_cfg_q <= hwdata[9:0];
      if (wr_tpar) tpar_q <= hwdata[17:0];
    end
  end

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // program cycle divider

  logic [15:0] div_cnt_q;
  logic        stb_q;
  wire         div_end = (div_cnt_q >= div_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_q <= 16'h0000;
      stb_q     <= 1'b0;
    end else if (!run_q) begin
      div_cnt_q <= 16'h0000;
      stb_q     <= 1'b0;
    end else begin
      div_cnt_q <= div_end ? 16'h0000 : div_cnt_q + 16'h0001;
      stb_q     <= div_end;
    end
  end

  assign cycle_stb = stb_q;

  ////////////////////////////////////////////////////////////////////////////
  // basic gate array

  genvar gi;
  generate
    for (gi = 0; gi < cyclg_pkg::NUM_GATES; gi++) begin : g_gate
      cyclg_gate #(
        .KIND (cyclg_pkg::cyclg_kind_type'(gi))
      ) u_gate (
        .hclk    (hclk),
        .hresetn (hresetn),
        .cyc_stb (stb_q),
        .gin     (gate_in[gi*4 +: 4]),
        .conn    (conn_q[gi*4 +: 4]),
        .inv     (inv_q[gi*4 +: 4]),
        .gout    (gate_out[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // special block common controls

  logic [4:0] sf_eff;
  logic       latch_q;
  logic       latch_d;
  logic       sfb_q;
  logic       sfb_d;
  logic       inv_hold_q;
  logic       inv_d;
  logic [15:0] cnt_d;

  // open inputs contribute zero; inversion only on connected ones
  assign sf_eff = sfb_cfg_q[4:0] & (sfb_in ^ sfb_cfg_q[9:5]);

  wire sf_en   = sf_eff[cyclg_pkg::SF_EN];
  wire sf_set  = sf_eff[cyclg_pkg::SF_SET];
  wire sf_rst  = sf_eff[cyclg_pkg::SF_RST];
  wire sf_inv  = sf_eff[cyclg_pkg::SF_INV];
  wire sf_rall = sf_eff[cyclg_pkg::SF_RALL];

  always_comb begin
    latch_d = latch_q;
    cnt_d   = cnt_q;
    inv_d   = inv_hold_q;
    sfb_d   = sfb_q;
    if (sf_en) begin
      inv_d = sf_inv;
      if (sf_rall) begin
        latch_d = 1'b0;
        cnt_d   = 16'h0000;
      end else if (cnt_q != 16'hFFFF) begin
        cnt_d = cnt_q + 16'h0001;
      end
      if (sf_rst) begin
        latch_d = 1'b0;
      end else if (sf_set) begin
        latch_d = 1'b1;
      end
      // reset forces the pin low even under inversion
      sfb_d = sf_rst ? 1'b0 : (latch_d ^ inv_d);
    end
  end

  // enable low keeps every piece of state as it was
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_q    <= 1'b0;
      sfb_q      <= 1'b0;
      inv_hold_q <= 1'b0;
      cnt_q      <= 16'h0000;
    end else if (stb_q) begin
      latch_q    <= latch_d;
      sfb_q      <= sfb_d;
      inv_hold_q <= inv_d;
      cnt_q      <= cnt_d;
    end
  end

  assign sfb_out = sfb_q;

  ////////////////////////////////////////////////////////////////////////////
  // time parameter decode and flag

  wire [7:0] tp_minor = tpar_q[cyclg_pkg::TP_MINOR +: 8];
  wire [7:0] tp_major = tpar_q[cyclg_pkg::TP_MAJOR +: 8];
  wire [1:0] tp_base  = tpar_q[cyclg_pkg::TP_BASE +: 2];
  wire [6:0] tp_mult  = (tp_base == cyclg_pkg::TB_SEC) ? cyclg_pkg::MULT_SEC : cyclg_pkg::MULT_MINHR;
  // seconds base counts hundredths, minutes base seconds, hours base minutes
  wire [15:0] tp_val  = 16'(tp_major * tp_mult) + {8'h00, tp_minor};

  assign tval_w = {tp_base, tp_val};
  wire elapsed  = (tp_val != 16'h0000) && (cnt_q >= tp_val);

  logic flag_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= 1'b0;
    end else if (stb_q) begin
      flag_q <= flag_in;
    end
  end
  assign flag_out = flag_q;

  assign status_w = {21'h00_0000, flag_q, elapsed, sfb_q, gate_out};

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_set_applied;
    stb_q && sf_en && sf_set && !sf_rst && !sf_inv && !sf_rall;
  endsequence

  sequence s_reset_applied;
    stb_q && sf_en && sf_rst;
  endsequence

  property p_set_high;
    @(posedge hclk) disable iff (!hresetn) s_set_applied |=> sfb_out;
  endproperty
  a_set_high: assert property (p_set_high) else $error("set did not raise output");

  property p_reset_wins;
    @(posedge hclk) disable iff (!hresetn) s_reset_applied |=> !sfb_out && !latch_q;
  endproperty
  a_reset_wins: assert property (p_reset_wins) else $error("reset did not clear output");

  property p_enable_ignore;
    @(posedge hclk) disable iff (!hresetn)
      stb_q && !sf_en |=> $stable(sfb_out) && $stable(cnt_q) && $stable(latch_q);
  endproperty
  a_enable_ignore: assert property (p_enable_ignore) else $error("disabled block changed state");

  property p_invert;
    @(posedge hclk) disable iff (!hresetn)
      stb_q && sf_en && !sf_rst |=> sfb_out == (latch_q ^ inv_hold_q);
  endproperty
  a_invert: assert property (p_invert) else $error("inverted output wrong");

  property p_rall_clear;
    @(posedge hclk) disable iff (!hresetn) stb_q && sf_en && sf_rall |=> cnt_q == 16'h0000;
  endproperty
  a_rall_clear: assert property (p_rall_clear) else $error("reset-all left count");

  property p_open_sf;
    @(posedge hclk) disable iff (!hresetn) sfb_cfg_q[4:0] == 5'h00 |-> sf_eff == 5'h00;
  endproperty
  a_open_sf: assert property (p_open_sf) else $error("open special input not low");

  property p_flag_prev;
    @(posedge hclk) disable iff (!hresetn)
      stb_q ##1 !stb_q |-> flag_out == $past(flag_in);
  endproperty
  a_flag_prev: assert property (p_flag_prev) else $error("flag not previous cycle value");

  property p_flag_stable;
    @(posedge hclk) disable iff (!hresetn) !stb_q |=> $stable(flag_out);
  endproperty
  a_flag_stable: assert property (p_flag_stable) else $error("flag moved within cycle");

  property p_time_hours;
    @(posedge hclk) disable iff (!hresetn)
      tp_base == cyclg_pkg::TB_HOUR && tp_major == 8'h04 && tp_minor == 8'h0A |-> tp_val == 16'h00FA;
  endproperty
  a_time_hours: assert property (p_time_hours) else $error("hours base decode wrong");

  property p_stb_gap;
    @(posedge hclk) disable iff (!hresetn) stb_q && div_q != 16'h0000 |=> !stb_q;
  endproperty
  a_stb_gap: assert property (p_stb_gap) else $error("cycle strobe too close");

endmodule // cyclg_top
`default_nettype wire

/* verification/cyclg_src.sv */
// stand-in for the neighbouring blocks and input terminals that feed the gate block
`timescale 1ns/10ps
`default_nettype none
module cyclg_src (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // next levels from the bench
  input  wire logic        ld,
  input  wire logic [31:0] d_gate,
  input  wire logic [4:0]  d_sfb,
  input  wire logic        d_flag,
  // levels seen by the block
  output logic      [31:0] gate_in,
  output logic      [4:0]  sfb_in,
  output logic             flag_in
);
  // levels move only on a clock edge, as a neighbour's registered output would
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_in <= 32'h0000_0000;
      sfb_in  <= 5'h00;
      flag_in <= 1'b0;
    end else if (ld) begin
      gate_in <= d_gate;
      sfb_in  <= d_sfb;
      flag_in <= d_flag;
    end
  end
endmodule // cyclg_src
`default_nettype wire

/* verification/tb_cyclg_top.sv */
// self-checking bench for the cycle logic gate block
`timescale 1ns/10ps
`default_nettype none
module tb_cyclg_top;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, d_gate = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [4:0]  d_sfb = 5'h00;
  logic        ld = 1'b0, d_flag = 1'b0;
  logic [31:0] gate_in, hrdata, rd, conn_v, inv_v, prev_e, cur_g;
  logic [4:0]  sfb_in;
  logic [7:0]  gate_out;
  logic        flag_in, hreadyout, hresp, sfb_out, flag_out, cycle_stb;
  wire logic   hready;
  int          failures = 0, tests_run = 0;
  logic [31:0] pats [5] = '{32'h0000_0000, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_0000, 32'h5A5A_5A5A};

  assign hready = hreadyout;
  always #10 hclk = ~hclk;

  cyclg_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .gate_in(gate_in), .sfb_in(sfb_in), .flag_in(flag_in),
    .gate_out(gate_out), .sfb_out(sfb_out), .flag_out(flag_out), .cycle_stb(cycle_stb));

  cyclg_src u_src (.hclk(hclk), .hresetn(hresetn), .ld(ld), .d_gate(d_gate), .d_sfb(d_sfb),
    .d_flag(d_flag), .gate_in(gate_in), .sfb_in(sfb_in), .flag_in(flag_in));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one single transfer; the master waits on hready in both phases
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, {24'h0, a}, d);
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
    chk({31'h0, hresp}, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // effective gate levels: open inputs of the and-type gates (0..3) read one, the rest zero
  function automatic logic [31:0] eff(input logic [31:0] g);
    return (conn_v & (g ^ inv_v)) | (~conn_v & 32'h0000_FFFF);
  endfunction

  function automatic logic [7:0] expg(input logic [31:0] e, input logic [31:0] p);
    logic [7:0] r;
    r[0] = &e[3:0];
    r[1] = &e[7:4] & ~&p[7:4];
    r[2] = ~&e[11:8];
    r[3] = ~&e[15:12] & &p[15:12];
    r[4] = |e[19:16];
    r[5] = ~|e[23:20];
    r[6] = e[24] ^ e[25];
    r[7] = ~e[28];
    return r;
  endfunction

  // the edge after a negedge that sees the strobe high is the update edge
  task automatic wait_stb;
    int k;
    k = 0;
    do begin
      @(negedge hclk);
      k++;
    end while (cycle_stb !== 1'b1 && k < 50);
    // a strobe that never comes is a failure, not a silent skip
    if (cycle_stb !== 1'b1) failures++;
    @(posedge hclk);
    #1;
  endtask

  task automatic cyc(input logic [31:0] g, input logic [4:0] s, input logic f);
    logic [31:0] e;
    @(posedge hclk);
    d_gate <= g;
    d_sfb  <= s;
    d_flag <= f;
    ld     <= 1'b1;
    @(posedge hclk);
    ld <= 1'b0;
    wait_stb;
    e = eff(g);
    chk({24'h0, gate_out}, {24'h0, expg(e, prev_e)});
    chk({31'h0, flag_out}, {31'h0, f});
    prev_e = e;
    cur_g  = g;
  endtask

  // two strobes with held inputs leave the edge history equal to the present levels
  task automatic cfg(input logic [31:0] c, input logic [31:0] i);
    wr(cyclg_pkg::CONN_OFF, c);
    wr(cyclg_pkg::INV_OFF, i);
    conn_v = c;
    inv_v  = i;
    wait_stb;
    wait_stb;
    prev_e = eff(cur_g);
  endtask

  task automatic runp;
    foreach (pats[i]) cyc(pats[i], 5'h00, pats[i][0]);
  endtask

  task automatic sf(input logic [4:0] s, input logic e);
    cyc(cur_g, s, 1'b0);
    chk({31'h0, sfb_out}, {31'h0, e});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    final_report;
  end

  initial begin
    cur_g  = 32'h0;
    conn_v = 32'hFFFF_FFFF;
    inv_v  = 32'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rchk({24'h0, cyclg_pkg::DIV_OFF}, {16'h0, cyclg_pkg::DIV_RST});
    rchk({24'h0, cyclg_pkg::CONN_OFF}, cyclg_pkg::CONN_RST);
    rchk({24'h0, cyclg_pkg::STAT_OFF}, 32'h0);
    rchk(32'h0000_0100, 32'h0);
    $display("test registers done");
    wr(cyclg_pkg::CONN_OFF, 32'hFFFF_FFFF);
    wr(cyclg_pkg::SFB_OFF, 32'h0000_001F);
    wr(cyclg_pkg::DIV_OFF, 32'h0000_0003);
    wr(cyclg_pkg::CTRL_OFF, 32'h0000_0001);
    prev_e = eff(32'h0);
    wait_stb;
    wr(cyclg_pkg::STAT_OFF, 32'hFFFF_FFFF);
    rchk({24'h0, cyclg_pkg::STAT_OFF}, {24'h0, expg(prev_e, prev_e)});
    $display("test start done");
    for (int v = 0; v < 16; v++) cyc({8{4'(v)}}, 5'h00, 1'(v));
    runp;
    $display("test truth tables done");
    cfg(32'h0, 32'h0);
    runp;
    cfg(32'hFFFF_FFFF, 32'hFFFF_FFFF);
    runp;
    cfg(32'hFFFF_FFFF, 32'h0);
    $display("test defaults and inversion done");
    sf(5'h05, 1'b1);
    sf(5'h07, 1'b0);
    sf(5'h05, 1'b1);
    sf(5'h02, 1'b1);
    sf(5'h0C, 1'b0);
    sf(5'h04, 1'b1);
    sf(5'h14, 1'b0);
    rchk({24'h0, cyclg_pkg::CNT_OFF}, 32'h0);
    wr(cyclg_pkg::SFB_OFF, 32'h0000_001E);
    sf(5'h05, 1'b0);
    wr(cyclg_pkg::SFB_OFF, 32'h0000_001F);
    sf(5'h05, 1'b1);
    $display("test special block done");
    for (int b = 0; b < 3; b++) begin
      wr(cyclg_pkg::TPAR_OFF, {14'h0, 2'(b), 16'h040A});
      rchk({24'h0, cyclg_pkg::TVAL_OFF},
           {14'h0, 2'(b), 16'h0004 * ((b == 0) ? 16'h0064 : 16'h003C) + 16'h000A});
    end
    $display("test time parameter done");
    final_report;
  end
endmodule // tb_cyclg_top
`default_nettype wire
